// ---- slssb_defines.svh ----
/*
 * Holds the register indices, field positions, reset values and widths of the
 * lane status bank as macros. It assumes that it is included by its bare name
 * and is used with the package slssb_pkg.
 */
`ifndef SLSSB_DEFINES_SVH
`define SLSSB_DEFINES_SVH

`define SLSSB_LANES 8
`define SLSSB_EVENTS 3
`define SLSSB_ADR_W 14
`define SLSSB_IDX_W 12
`define SLSSB_DAT_W 32
`define SLSSB_SEL_W 4

`define SLSSB_IDX_FRAMING 12'h471
`define SLSSB_IDX_CHECKSUM 12'h472
`define SLSSB_IDX_ALIGN 12'h473
`define SLSSB_IDX_CTRL 12'h480
`define SLSSB_IDX_IRQ_STATUS 12'h481
`define SLSSB_IDX_IRQ_CLEAR 12'h482
`define SLSSB_IDX_IRQ_ENABLE 12'h483

`define SLSSB_CTRL_SKIP_BIT 0
`define SLSSB_EVT_FRAMING_LOST 0
`define SLSSB_EVT_CHECKSUM_BAD 1
`define SLSSB_EVT_ALIGN_LOST 2

`define SLSSB_STATUS_RESET 8'h00
`define SLSSB_CTRL_RESET 1'b0
`define SLSSB_EVT_RESET 3'h0
`define SLSSB_WORD_ZERO 32'h00000000
`define SLSSB_PAD_ZERO 24'h000000
`define SLSSB_PAD_CTRL 31'h00000000
`define SLSSB_PAD_EVT 29'h00000000

`endif

// ---- slssb_pkg.sv ----
/*
 * Types shared by the lane status bank: lane status carrier, bus request and
 * answer, and the state records of the bank, fall and interrupt modules. Assumes slssb_defines.svh.
 */
`default_nettype none
`include "slssb_defines.svh"

package slssb_pkg;

    typedef struct packed {
        logic [`SLSSB_LANES-1:0] framing;
        logic [`SLSSB_LANES-1:0] checksum;
        logic [`SLSSB_LANES-1:0] align;
    } slssb_lane_status_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [`SLSSB_SEL_W-1:0] sel;
        logic [`SLSSB_ADR_W-1:0] adr;
        logic [`SLSSB_DAT_W-1:0] dat;
    } slssb_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [`SLSSB_DAT_W-1:0] dat;
    } slssb_wb_rsp_t;

    typedef struct packed {
        slssb_lane_status_t lanes;
        logic skip;
        logic ack;
        logic [`SLSSB_DAT_W-1:0] rdata;
    } slssb_bank_state_t;

    typedef struct packed {
        logic [`SLSSB_LANES-1:0] prev;
    } slssb_fall_state_t;

    typedef struct packed {
        logic [`SLSSB_EVENTS-1:0] status;
        logic [`SLSSB_EVENTS-1:0] enable;
    } slssb_irq_state_t;

endpackage : slssb_pkg
`default_nettype wire

// ---- slssb_lane_fall.sv ----
/*
 * Detects any lane of a status vector dropping from 1 to 0 and gives a one
 * cycle pulse. Assumes its input is already on clk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "slssb_defines.svh"

module slssb_lane_fall (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Lane vector and gating
    input wire logic [`SLSSB_LANES-1:0] lanes,
    input wire logic arm,
    // Event
    output logic fell
);

    slssb_pkg::slssb_fall_state_t stateQ;
    slssb_pkg::slssb_fall_state_t stateD;

    always_comb begin
        stateD = stateQ;
        stateD.prev = lanes;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stateQ.prev <= `SLSSB_STATUS_RESET;
        end else begin
            stateQ <= stateD;
        end
    end

    // A lane that never locked cannot report a loss, hence the stored history.
    assign fell = arm && |(stateQ.prev & ~lanes);

    chk_fall_pulse: assert property (@(posedge clk) disable iff (!resetn)
        (arm && ($past(lanes) & ~lanes) != `SLSSB_STATUS_RESET) |-> fell)
        else $error("lane loss not reported");

endmodule : slssb_lane_fall
`default_nettype wire

// ---- slssb_irq_sticky.sv ----
/*
 * Sticky event flags with a write-one-to-clear port, an enable register and a
 * level interrupt. Assumes write strobes are one-cycle pulses on clk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "slssb_defines.svh"

module slssb_irq_sticky (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Events
    input wire logic [`SLSSB_EVENTS-1:0] events,
    // Software access
    input wire logic clearWrite,
    input wire logic enableWrite,
    input wire logic [`SLSSB_EVENTS-1:0] writeData,
    // State and interrupt
    output logic [`SLSSB_EVENTS-1:0] status,
    output logic [`SLSSB_EVENTS-1:0] enable,
    output logic irq
);

    slssb_pkg::slssb_irq_state_t stateQ;
    slssb_pkg::slssb_irq_state_t stateD;

    always_comb begin
        stateD = stateQ;
        // Setting is applied after clearing so an event in the clear cycle survives.
        if (clearWrite) begin
            stateD.status = stateQ.status & ~writeData;
        end
        stateD.status = stateD.status | events;
        if (enableWrite) begin
            stateD.enable = writeData;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stateQ.status <= `SLSSB_EVT_RESET;
            stateQ.enable <= `SLSSB_EVT_RESET;
        end else begin
            stateQ <= stateD;
        end
    end

    assign status = stateQ.status;
    assign enable = stateQ.enable;
    assign irq = |(stateQ.status & stateQ.enable);

    chk_set_wins: assert property (@(posedge clk) disable iff (!resetn)
        (clearWrite && (events & writeData) != `SLSSB_EVT_RESET)
        |=> (status & $past(events & writeData)) == $past(events & writeData))
        else $error("event lost against clear");

endmodule : slssb_irq_sticky
`default_nettype wire

// ---- slssb_status_bank.sv ----
/*
 * Per-lane status bank of the serial receiver: framing lock, configuration
 * checksum and alignment sequence bits, a control register and interrupt
 * flags, all on a classic Wishbone slave with 32-bit data. Assumes lane
 * status arrives from receiver logic on clk and that the master holds its
 * request until it sees ack.
 */
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "slssb_defines.svh"

module slssb_status_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Wishbone slave
    input wire slssb_pkg::slssb_wb_req_t wbReq,
    output slssb_pkg::slssb_wb_rsp_t wbRsp,
    // Lane state from the receiver core
    input wire slssb_pkg::slssb_lane_status_t laneStatus,
    // Control out and interrupt
    output logic skipAlignmentSequence,
    output logic irq
);

    slssb_pkg::slssb_bank_state_t stateQ;
    slssb_pkg::slssb_bank_state_t stateD;

    logic [`SLSSB_IDX_W-1:0] regIndex;
    logic accept;
    logic [`SLSSB_DAT_W-1:0] readWord;
    wire logic [`SLSSB_EVENTS-1:0] events;
    logic [`SLSSB_EVENTS-1:0] irqStatus;
    logic [`SLSSB_EVENTS-1:0] irqEnable;
    logic clearWrite;
    logic enableWrite;

    assign regIndex = wbReq.adr[`SLSSB_ADR_W-1:2];
    // Ack is registered, so a request is taken only while no ack is out.
    assign accept = wbReq.cyc && wbReq.stb && !stateQ.ack;
    assign clearWrite = accept && wbReq.we && wbReq.sel[0]
        && regIndex == `SLSSB_IDX_IRQ_CLEAR;
    assign enableWrite = accept && wbReq.we && wbReq.sel[0]
        && regIndex == `SLSSB_IDX_IRQ_ENABLE;

    // Lane n is bit n in every status word.
    always_comb begin
        case (regIndex)
            `SLSSB_IDX_FRAMING: begin
                readWord = {`SLSSB_PAD_ZERO, stateQ.lanes.framing};
            end
            `SLSSB_IDX_CHECKSUM: begin
                readWord = {`SLSSB_PAD_ZERO, stateQ.lanes.checksum};
            end
            `SLSSB_IDX_ALIGN: begin
                readWord = {`SLSSB_PAD_ZERO, stateQ.lanes.align};
            end
            `SLSSB_IDX_CTRL: begin
                readWord = {`SLSSB_PAD_CTRL, stateQ.skip};
            end
            `SLSSB_IDX_IRQ_STATUS: begin
                readWord = {`SLSSB_PAD_EVT, irqStatus};
            end
            `SLSSB_IDX_IRQ_ENABLE: begin
                readWord = {`SLSSB_PAD_EVT, irqEnable};
            end
            default: begin
                readWord = `SLSSB_WORD_ZERO;
            end
        endcase
    end

    always_comb begin
        stateD = stateQ;
        // The bank mirrors the live lane state each cycle; nothing latches.
        stateD.lanes = laneStatus;
        stateD.ack = 1'b0;
        if (accept) begin
            stateD.ack = 1'b1;
            if (wbReq.we) begin
                // Writes to the three status words fall through here unused.
                if (regIndex == `SLSSB_IDX_CTRL && wbReq.sel[0]) begin
                    stateD.skip = wbReq.dat[`SLSSB_CTRL_SKIP_BIT];
                end
            end else begin
                stateD.rdata = readWord;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stateQ.lanes.framing <= `SLSSB_STATUS_RESET;
            stateQ.lanes.checksum <= `SLSSB_STATUS_RESET;
            stateQ.lanes.align <= `SLSSB_STATUS_RESET;
            stateQ.skip <= `SLSSB_CTRL_RESET;
            stateQ.ack <= 1'b0;
            stateQ.rdata <= `SLSSB_WORD_ZERO;
        end else begin
            stateQ <= stateD;
        end
    end

    assign wbRsp.ack = stateQ.ack;
    assign wbRsp.dat = stateQ.rdata;
    assign skipAlignmentSequence = stateQ.skip;

    // Loss events are meaningless with the sequence skipped, so they are held off.
    slssb_lane_fall u_fall_framing (
        .clk(clk),
        .resetn(resetn),
        .lanes(stateQ.lanes.framing),
        .arm(!stateQ.skip),
        .fell(events[`SLSSB_EVT_FRAMING_LOST])
    );

    slssb_lane_fall u_fall_checksum (
        .clk(clk),
        .resetn(resetn),
        .lanes(stateQ.lanes.checksum),
        .arm(!stateQ.skip),
        .fell(events[`SLSSB_EVT_CHECKSUM_BAD])
    );

    slssb_lane_fall u_fall_align (
        .clk(clk),
        .resetn(resetn),
        .lanes(stateQ.lanes.align),
        .arm(!stateQ.skip),
        .fell(events[`SLSSB_EVT_ALIGN_LOST])
    );

    slssb_irq_sticky u_irq (
        .clk(clk),
        .resetn(resetn),
        .events(events),
        .clearWrite(clearWrite),
        .enableWrite(enableWrite),
        .writeData(wbReq.dat[`SLSSB_EVENTS-1:0]),
        .status(irqStatus),
        .enable(irqEnable),
        .irq(irq)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    chk_framing_follow: assert property (
        ##1 stateQ.lanes.framing == $past(laneStatus.framing))
        else $error("framing bits do not follow lanes");

    chk_checksum_read: assert property (
        (wbRsp.ack && !wbReq.we && regIndex == `SLSSB_IDX_CHECKSUM)
        |-> wbRsp.dat == {`SLSSB_PAD_ZERO, $past(stateQ.lanes.checksum)})
        else $error("checksum word read wrong");

    chk_align_read: assert property (
        (wbRsp.ack && !wbReq.we && regIndex == `SLSSB_IDX_ALIGN)
        |-> wbRsp.dat == {`SLSSB_PAD_ZERO, $past(stateQ.lanes.align)})
        else $error("alignment word read wrong");

    chk_lane0_align: assert property (
        (wbRsp.ack && !wbReq.we && regIndex == `SLSSB_IDX_ALIGN)
        |-> wbRsp.dat[0] == $past(laneStatus.align[0], 2))
        else $error("lane 0 alignment not at bit 0");

    chk_lane7_framing: assert property (
        (wbRsp.ack && !wbReq.we && regIndex == `SLSSB_IDX_FRAMING)
        |-> wbRsp.dat[7] == $past(laneStatus.framing[7], 2))
        else $error("lane 7 framing not at bit 7");

    chk_status_ro: assert property (
        (accept && wbReq.we && regIndex >= `SLSSB_IDX_FRAMING
            && regIndex <= `SLSSB_IDX_ALIGN)
        |=> stateQ.skip == $past(stateQ.skip) && stateQ.lanes == $past(laneStatus))
        else $error("write to status word had effect");

    chk_reset_zero: assert property (@(posedge clk) disable iff (1'b0)
        (!resetn ##1 !resetn) |-> stateQ.lanes == '0 && !wbRsp.ack && !irq
            && wbRsp.dat == `SLSSB_WORD_ZERO && !skipAlignmentSequence)
        else $error("status not zero in reset");

    chk_skip_gates: assert property (
        stateQ.skip |-> events == `SLSSB_EVT_RESET)
        else $error("event raised while sequence skipped");

    chk_ack_single: assert property (
        (wbReq.cyc && wbReq.stb && !wbRsp.ack) |=> wbRsp.ack ##1 !wbRsp.ack)
        else $error("ack not a single cycle");

    // The checks below, with those above, pin down the whole register map, so that a slip in the
    // decode or in a field position shows at the first access that meets it.
    chk_framing_read: assert property (
        (wbRsp.ack && !wbReq.we && regIndex == `SLSSB_IDX_FRAMING)
        |-> wbRsp.dat == {`SLSSB_PAD_ZERO, $past(stateQ.lanes.framing)})
        else $error("framing word read wrong");

    chk_checksum_follow: assert property (
        ##1 stateQ.lanes.checksum == $past(laneStatus.checksum))
        else $error("checksum bits do not follow lanes");

    chk_align_follow: assert property (
        ##1 stateQ.lanes.align == $past(laneStatus.align))
        else $error("alignment bits do not follow lanes");

    chk_lane7_checksum: assert property (
        (wbRsp.ack && !wbReq.we && regIndex == `SLSSB_IDX_CHECKSUM)
        |-> wbRsp.dat[`SLSSB_LANES-1] == $past(laneStatus.checksum[`SLSSB_LANES-1], 2))
        else $error("lane 7 checksum not at bit 7");

    chk_lane0_checksum: assert property (
        (wbRsp.ack && !wbReq.we && regIndex == `SLSSB_IDX_CHECKSUM)
        |-> wbRsp.dat[0] == $past(laneStatus.checksum[0], 2))
        else $error("lane 0 checksum not at bit 0");

    chk_ctrl_write: assert property (
        (accept && wbReq.we && wbReq.sel[0] && regIndex == `SLSSB_IDX_CTRL)
        |=> skipAlignmentSequence == $past(wbReq.dat[`SLSSB_CTRL_SKIP_BIT]))
        else $error("control write not taken");

    chk_ctrl_hold: assert property (
        !(accept && wbReq.we && wbReq.sel[0] && regIndex == `SLSSB_IDX_CTRL)
        |=> skipAlignmentSequence == $past(skipAlignmentSequence))
        else $error("control bit changed without write");

    chk_ctrl_read: assert property (
        (wbRsp.ack && !wbReq.we && regIndex == `SLSSB_IDX_CTRL)
        |-> wbRsp.dat == {`SLSSB_PAD_CTRL, $past(skipAlignmentSequence)})
        else $error("control word read wrong");

    chk_irq_status_read: assert property (
        (wbRsp.ack && !wbReq.we && regIndex == `SLSSB_IDX_IRQ_STATUS)
        |-> wbRsp.dat == {`SLSSB_PAD_EVT, $past(irqStatus)})
        else $error("interrupt status read wrong");

    chk_irq_enable_read: assert property (
        (wbRsp.ack && !wbReq.we && regIndex == `SLSSB_IDX_IRQ_ENABLE)
        |-> wbRsp.dat == {`SLSSB_PAD_EVT, $past(irqEnable)})
        else $error("interrupt enable read wrong");

    chk_unmapped_zero: assert property (
        (wbRsp.ack && !wbReq.we && regIndex != `SLSSB_IDX_FRAMING
            && regIndex != `SLSSB_IDX_CHECKSUM && regIndex != `SLSSB_IDX_ALIGN
            && regIndex != `SLSSB_IDX_CTRL && regIndex != `SLSSB_IDX_IRQ_STATUS
            && regIndex != `SLSSB_IDX_IRQ_ENABLE)
        |-> wbRsp.dat == `SLSSB_WORD_ZERO)
        else $error("unmapped word not zero");

    chk_upper_zero: assert property (
        (wbRsp.ack && !wbReq.we)
        |-> wbRsp.dat[`SLSSB_DAT_W-1:`SLSSB_LANES] == `SLSSB_PAD_ZERO)
        else $error("upper read bits not zero");

    chk_rdata_hold: assert property (
        !(accept && !wbReq.we) |=> wbRsp.dat == $past(wbRsp.dat))
        else $error("read data changed without read");

    chk_ack_answers: assert property (
        wbRsp.ack |-> $past(accept))
        else $error("ack without request");

    chk_ack_idle: assert property (
        !(wbReq.cyc && wbReq.stb) |=> !wbRsp.ack)
        else $error("ack while bus idle");

    chk_irq_level: assert property (
        irq == |(irqStatus & irqEnable))
        else $error("interrupt level wrong");

    chk_enable_write: assert property (
        enableWrite |=> irqEnable == $past(wbReq.dat[`SLSSB_EVENTS-1:0]))
        else $error("interrupt enable write not taken");

    chk_clear_write: assert property (
        (clearWrite && events == `SLSSB_EVT_RESET)
        |=> (irqStatus & $past(wbReq.dat[`SLSSB_EVENTS-1:0])) == `SLSSB_EVT_RESET)
        else $error("interrupt clear not taken");

    chk_sel_guard: assert property (
        (accept && wbReq.we && !wbReq.sel[0])
        |=> skipAlignmentSequence == $past(skipAlignmentSequence)
            && irqEnable == $past(irqEnable))
        else $error("write with byte 0 unselected had effect");

    chk_framing_event: assert property (
        (!stateQ.skip && ($past(stateQ.lanes.framing) & ~stateQ.lanes.framing)
            != `SLSSB_STATUS_RESET)
        |=> irqStatus[`SLSSB_EVT_FRAMING_LOST])
        else $error("framing loss not flagged");

    chk_checksum_event: assert property (
        (!stateQ.skip && ($past(stateQ.lanes.checksum) & ~stateQ.lanes.checksum)
            != `SLSSB_STATUS_RESET)
        |=> irqStatus[`SLSSB_EVT_CHECKSUM_BAD])
        else $error("checksum failure not flagged");

    chk_align_event: assert property (
        (!stateQ.skip && ($past(stateQ.lanes.align) & ~stateQ.lanes.align)
            != `SLSSB_STATUS_RESET)
        |=> irqStatus[`SLSSB_EVT_ALIGN_LOST])
        else $error("alignment loss not flagged");

endmodule : slssb_status_bank
`default_nettype wire

// ---- slssb_lane_source.sv ----
/*
 * Partner model of the far end of the lane status bank: it plays the receiver
 * core and its lanes, presenting the lane state that the bench asks for.
 * Assumes the bench changes target just after a rising edge of clk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "slssb_defines.svh"

module slssb_lane_source (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Lane state wanted by the bench
    input wire slssb_pkg::slssb_lane_status_t target,
    // Live lane state towards the bank
    output slssb_pkg::slssb_lane_status_t laneStatus
);
    // Every lane reads as lost while the link is held in reset.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            laneStatus <= '0;
        end else begin
            laneStatus <= target;
        end
    end
endmodule : slssb_lane_source
`default_nettype wire

// ---- slssb_status_bank_bench.sv ----
/*
 * Self-checking bench of the lane status bank: Wishbone read and write tasks,
 * a lane source model and sequences of accesses with expected values.
 * Assumes the design files and slssb_defines.svh are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "slssb_defines.svh"

module slssb_status_bank_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    slssb_pkg::slssb_wb_req_t wbReq = '0;
    slssb_pkg::slssb_wb_rsp_t wbRsp;
    slssb_pkg::slssb_lane_status_t target = '0;
    slssb_pkg::slssb_lane_status_t laneStatus;
    logic skipAlignmentSequence;
    logic irq;
    int errCount = 0;
    int checksDone = 0;
    logic [7:0] one;

    always #5 clk = ~clk;

    slssb_lane_source u_src (.clk(clk), .resetn(resetn), .target(target),
        .laneStatus(laneStatus));
    slssb_status_bank u_dut (.clk(clk), .resetn(resetn), .wbReq(wbReq), .wbRsp(wbRsp),
        .laneStatus(laneStatus), .skipAlignmentSequence(skipAlignmentSequence), .irq(irq));

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic check_word(input string what, input logic [31:0] exp,
                              input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    // The wait is bounded so that a slave that never answers ends the run.
    task automatic wb_access(input logic we, input logic [3:0] sel, input logic [11:0] idx,
                             input logic [31:0] wdat, output logic [31:0] rdat);
        int n;
        @(posedge clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: {idx, 2'b00}, dat: wdat};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbRsp.ack !== 1'b1 && n < 20);
        if (wbRsp.ack !== 1'b1) begin
            errCount++;
            $display("MISMATCH wishbone ack expected 1 seen %b", wbRsp.ack);
            complete_run();
        end else begin
            rdat = wbRsp.dat;
            wbReq <= '0;
        end
    endtask : wb_access

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        wb_access(1'b1, 4'hF, idx, {24'h000000, d}, unused);
    endtask : wr

    // Byte 0 unselected: the write must leave every register as it was.
    task automatic wr_unsel(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        wb_access(1'b1, 4'hE, idx, {24'h000000, d}, unused);
    endtask : wr_unsel

    task automatic rd_chk(input string what, input logic [11:0] idx, input logic [7:0] exp);
        logic [31:0] got;
        wb_access(1'b0, 4'hF, idx, 32'h00000000, got);
        check_word(what, {24'h000000, exp}, got);
    endtask : rd_chk

    task automatic set_lanes(input logic [7:0] f, input logic [7:0] c, input logic [7:0] a);
        @(posedge clk);
        target <= '{framing: f, checksum: c, align: a};
        repeat (4) @(posedge clk);
    endtask : set_lanes

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd_chk("framing reset", `SLSSB_IDX_FRAMING, 8'h00);
        rd_chk("checksum reset", `SLSSB_IDX_CHECKSUM, 8'h00);
        rd_chk("align reset", `SLSSB_IDX_ALIGN, 8'h00);
        rd_chk("irq enable reset", `SLSSB_IDX_IRQ_ENABLE, 8'h00);
        set_lanes(8'h81, 8'hA5, 8'h01);
        rd_chk("framing", `SLSSB_IDX_FRAMING, 8'h81);
        rd_chk("checksum", `SLSSB_IDX_CHECKSUM, 8'hA5);
        rd_chk("align", `SLSSB_IDX_ALIGN, 8'h01);
        wr(`SLSSB_IDX_FRAMING, 8'h00);
        wr(`SLSSB_IDX_CHECKSUM, 8'hFF);
        wr(`SLSSB_IDX_ALIGN, 8'hFF);
        rd_chk("framing kept", `SLSSB_IDX_FRAMING, 8'h81);
        rd_chk("checksum kept", `SLSSB_IDX_CHECKSUM, 8'hA5);
        rd_chk("align kept", `SLSSB_IDX_ALIGN, 8'h01);
        // One lane at a time, so a swapped or shifted bit shows at once.
        for (int i = 0; i < `SLSSB_LANES; i++) begin
            one = 8'h01 << i;
            set_lanes(one, ~one, 8'h80 >> i);
            rd_chk("framing walk", `SLSSB_IDX_FRAMING, one);
            rd_chk("checksum walk", `SLSSB_IDX_CHECKSUM, ~one);
            rd_chk("align walk", `SLSSB_IDX_ALIGN, 8'h80 >> i);
        end
        set_lanes(8'hFF, 8'hFF, 8'hFF);
        rd_chk("framing regained", `SLSSB_IDX_FRAMING, 8'hFF);
        wr(`SLSSB_IDX_IRQ_ENABLE, 8'h07);
        wr(`SLSSB_IDX_IRQ_CLEAR, 8'h07);
        rd_chk("irq status cleared", `SLSSB_IDX_IRQ_STATUS, 8'h00);
        check_word("irq idle", 32'h00000000, {31'h00000000, irq});
        // The clear is timed to land in the cycle of the framing loss event,
        // so the sticky bit only survives if the set wins.
        fork
            set_lanes(8'h7F, 8'hFF, 8'hFF);
            begin
                repeat (2) @(posedge clk);
                wr(`SLSSB_IDX_IRQ_CLEAR, 8'h01);
            end
        join
        rd_chk("irq framing lost", `SLSSB_IDX_IRQ_STATUS, 8'h01);
        check_word("irq raised", 32'h00000001, {31'h00000000, irq});
        wr(`SLSSB_IDX_IRQ_ENABLE, 8'h06);
        check_word("irq masked", 32'h00000000, {31'h00000000, irq});
        rd_chk("irq status sticky", `SLSSB_IDX_IRQ_STATUS, 8'h01);
        wr(`SLSSB_IDX_IRQ_CLEAR, 8'h01);
        rd_chk("irq clear reads", `SLSSB_IDX_IRQ_CLEAR, 8'h00);
        set_lanes(8'h7F, 8'h7F, 8'h7E);
        rd_chk("irq checksum align", `SLSSB_IDX_IRQ_STATUS, 8'h06);
        check_word("irq enabled", 32'h00000001, {31'h00000000, irq});
        wr(`SLSSB_IDX_IRQ_CLEAR, 8'h06);
        check_word("irq released", 32'h00000000, {31'h00000000, irq});
        // While the alignment sequence is skipped the bits are still shown but
        // raise nothing; software reading them here must disregard them.
        wr(`SLSSB_IDX_CTRL, 8'h01);
        check_word("skip out", 32'h00000001, {31'h00000000, skipAlignmentSequence});
        rd_chk("ctrl", `SLSSB_IDX_CTRL, 8'h01);
        set_lanes(8'h00, 8'h00, 8'h00);
        rd_chk("framing skipped", `SLSSB_IDX_FRAMING, 8'h00);
        rd_chk("irq skipped", `SLSSB_IDX_IRQ_STATUS, 8'h00);
        wr(`SLSSB_IDX_CTRL, 8'h00);
        rd_chk("unmapped", 12'h490, 8'h00);
        wr(12'h490, 8'hFF);
        rd_chk("ctrl after unmapped", `SLSSB_IDX_CTRL, 8'h00);
        wr_unsel(`SLSSB_IDX_CTRL, 8'h01);
        rd_chk("ctrl byte 0 unselected", `SLSSB_IDX_CTRL, 8'h00);
        set_lanes(8'h3C, 8'h3C, 8'h3C);
        wr(`SLSSB_IDX_CTRL, 8'h01);
        rd_chk("ctrl before reset", `SLSSB_IDX_CTRL, 8'h01);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        check_word("read data in reset", 32'h00000000, wbRsp.dat);
        check_word("skip in reset", 32'h00000000, {31'h00000000, skipAlignmentSequence});
        resetn <= 1'b1;
        @(posedge clk);
        // The lanes read as lost during the reset but the target stays 3C, so the words show them again by the first read.
        rd_chk("framing second reset", `SLSSB_IDX_FRAMING, 8'h3C);
        rd_chk("ctrl second reset", `SLSSB_IDX_CTRL, 8'h00);
        rd_chk("irq status second reset", `SLSSB_IDX_IRQ_STATUS, 8'h00);
        rd_chk("irq enable second reset", `SLSSB_IDX_IRQ_ENABLE, 8'h00);
        complete_run();
    end
endmodule : slssb_status_bank_bench
`default_nettype wire
